// ==== common/rtcuc_pkg.sv ====
`default_nettype none
package rtcuc_pkg;
  // timebase
  localparam int CLK_HZ         = 10_000_000;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TICK_W         = 24;
  // bus widths and memory size
  localparam int ADDR_W    = 13;
  localparam int DATA_W    = 8;
  localparam int MEM_WORDS = 8176;
  localparam logic [8:0] REG_PAGE = 9'h1ff;
  // register offsets
  localparam logic [12:0] ADDR_FLAGS    = 13'h1ff0;
  localparam logic [12:0] ADDR_SPARE    = 13'h1ff1;
  localparam logic [12:0] ADDR_ALM_SEC  = 13'h1ff2;
  localparam logic [12:0] ADDR_ALM_MIN  = 13'h1ff3;
  localparam logic [12:0] ADDR_ALM_HOUR = 13'h1ff4;
  localparam logic [12:0] ADDR_ALM_DATE = 13'h1ff5;
  localparam logic [12:0] ADDR_INT_EN   = 13'h1ff6;
  localparam logic [12:0] ADDR_WATCHDOG = 13'h1ff7;
  localparam logic [12:0] ADDR_CONTROL  = 13'h1ff8;
  localparam logic [12:0] ADDR_SECONDS  = 13'h1ff9;
  localparam logic [12:0] ADDR_MINUTES  = 13'h1ffa;
  localparam logic [12:0] ADDR_HOURS    = 13'h1ffb;
  localparam logic [12:0] ADDR_CENT_DAY = 13'h1ffc;
  localparam logic [12:0] ADDR_DATE     = 13'h1ffd;
  localparam logic [12:0] ADDR_MONTH    = 13'h1ffe;
  localparam logic [12:0] ADDR_YEAR     = 13'h1fff;
  // field positions
  localparam int FLG_WDF  = 7;
  localparam int FLG_AF   = 6;
  localparam int FLG_BL   = 4;
  localparam int CTL_SET  = 7;
  localparam int CTL_HALT = 6;
  localparam int CTL_SIGN = 5;
  localparam int SEC_STOP = 7;
  localparam int CDW_FT   = 6;
  localparam int CDW_CEB  = 5;
  localparam int CDW_CB   = 4;
  localparam int WD_STEER = 7;
  localparam int INT_AFE  = 7;
  localparam int INT_ABE  = 5;
  // stored bits of each time register (others fixed zero or held apart)
  localparam logic [7:0] MASK_SEC   = 8'h7f;
  localparam logic [7:0] MASK_MIN   = 8'h7f;
  localparam logic [7:0] MASK_HOUR  = 8'h3f;
  localparam logic [7:0] MASK_CDW   = 8'h17;
  localparam logic [7:0] MASK_DATE  = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  // bcd limits
  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] DAY_MAX   = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // refresh sequencer
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_XFER = 3'b010,
    S_LOAD = 3'b100
  } rtcuc_state_t;
endpackage
`default_nettype wire

// ==== rtl/rtcuc_top.sv ====
// How it works
// RQ1: supply below trip level deselects the part and blocks every write.
// RQ2: while deselected all outputs float and all bus inputs are ignored; an alarm still pulls the interrupt pin if backup alarm is enabled.
// RQ3: failure mid-write may hit only the addressed byte, nothing else.
// RQ4: host should halt visible updates before reading the time.
// RQ5: read-halt bit set freezes visible time registers; counters keep running.
// RQ6: frozen registers show the time current when the halt was requested.
// RQ7: all visible registers refresh in one transfer; a started transfer completes.
// RQ8: after read-halt clears, refresh resumes within one second.
// RQ9: set-time bit also freezes visible updates so new time can be loaded.
// RQ10: clearing set-time copies time registers into counters; refresh within a second.
// RQ11: host loads time in bcd, 24 hour format.
// RQ12: power-up after supply failure clears set-time and read-halt bits.
// RQ13: oscillator-stop bit stops the oscillator; clearing restarts within one second.
// RQ14: frequency-test, oscillator-stop, century-enable act without set-time.
// RQ15: fixed-zero bits are written zero; unused bits hold either value.
// RQ16: flags byte shows watchdog, alarm, battery-low; other bits read zero.
// RQ17: control byte holds set-time, read-halt, calibration sign and magnitude.
// RQ18: century/day byte holds test, century enable, century bit, weekday.
// RQ19: watchdog byte holds steering bit, multiplier and resolution select.
// RQ20: interrupt byte holds alarm flag enable and battery backup alarm enable.
// RQ21: alarm bytes hold bcd date, hours, minutes, seconds plus repeat bits.
// RQ22: calibration sign one is positive; magnitude spans 0 to 31.
// RQ23: reading flags clears watchdog and alarm flags and releases interrupt.
`timescale 1ns/100ps
`default_nettype none
module rtcuc_top #(
  parameter int unsigned SEC_CYCLES = rtcuc_pkg::TICK_CYCLES
) (
  // clock, reset and freeze
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  // supply monitor, high while the supply sits in the deselect window
  input  wire logic        POWER_FAIL_DESELECT_LEVEL,
  // asynchronous sram bus
  input  wire logic [12:0] ADDR,
  input  wire logic        E_N,
  input  wire logic        G_N,
  input  wire logic        W_N,
  input  wire logic [7:0]  DQ_IN,
  output logic      [7:0]  DQ_OUT,
  output logic             DQ_OE,
  // event sources from neighbouring logic
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic        ALARM_MATCH,
  input  wire logic        BATTERY_LOW,
  // open-drain interrupt pin
  output logic             IRQ_OUT,
  output logic             IRQ_OE
);

  // bcd increment with wrap, carry in bit 8
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    if (v >= hi) begin
      return {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last date of a month in bcd, leap years every fourth year
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  // two-flop synchronisers for the bus and supply pins; event inputs are used unsynchronised
  logic [12:0] addr_s1, addr_s2;
  logic [7:0]  dq_s1, dq_s2;
  logic [2:0]  strb_s1, strb_s2;
  logic        pf_s1, pf_s2;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_s1 <= 13'h0000;
      addr_s2 <= 13'h0000;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
      strb_s1 <= 3'h7;
      strb_s2 <= 3'h7;
      pf_s1   <= 1'b1;
      pf_s2   <= 1'b1;
    end else if (CLK_EN) begin
      addr_s1 <= ADDR;
      addr_s2 <= addr_s1;
      dq_s1   <= DQ_IN;
      dq_s2   <= dq_s1;
      strb_s1 <= {E_N, G_N, W_N};
      strb_s2 <= strb_s1;
      pf_s1   <= POWER_FAIL_DESELECT_LEVEL;
      pf_s2   <= pf_s1;
    end
  end

  // bus decode; a failing supply masks every strobe
  logic pf;
  logic rd_act;
  logic wr_act;
  assign pf     = pf_s2;
  assign rd_act = !pf && !strb_s2[2] && !strb_s2[1] && strb_s2[0]; // [RQ2]
  assign wr_act = !pf && !strb_s2[2] && !strb_s2[0];                // [RQ1]

  // bus state
  logic        rd_prev, next_rd_prev;
  logic        wr_prev, next_wr_prev;
  logic [12:0] addr_prev, next_addr_prev;
  logic [12:0] wr_addr, next_wr_addr;
  logic [7:0]  wr_data, next_wr_data;
  logic [7:0]  next_dq_out;
  logic        next_dq_oe;
  logic        rd_ev;
  logic        commit;
  logic        page_wr;
  logic        flag_rd;
  logic [7:0]  rd_byte;

  // register and timekeeping state
  logic [7:0]          vis [0:15];
  logic [7:0]          next_vis [0:15];
  logic [7:0]          cnt [0:6];
  logic [7:0]          next_cnt [0:6];
  logic [7:0]          mem [0:rtcuc_pkg::MEM_WORDS-1];
  logic                osc_stop, next_osc_stop;
  logic                ft, next_ft;
  logic                ceb, next_ceb;
  logic                watchdog_flag, next_wdf;
  logic                af, next_af;
  logic                bl, next_bl;
  logic                pf_prev;
  logic                irq, next_irq;
  logic [23:0]         pre, next_pre;
  rtcuc_pkg::rtcuc_state_t state, next_state;
  logic                tick;
  logic                halted;

  assign halted  = vis[rtcuc_pkg::ADDR_CONTROL[3:0]][rtcuc_pkg::CTL_SET]
                 | vis[rtcuc_pkg::ADDR_CONTROL[3:0]][rtcuc_pkg::CTL_HALT];
  assign tick    = !osc_stop && (pre == 24'(SEC_CYCLES - 1));
  // a write is committed when the strobe ends; a supply drop aborts it
  assign commit  = wr_prev && !wr_act && !pf; // [RQ1] [RQ3]
  assign page_wr = commit && (wr_addr[12:4] == rtcuc_pkg::REG_PAGE);
  // a new read starts on strobe entry or on an address change
  assign rd_ev   = rd_act && (!rd_prev || addr_s2 != addr_prev);
  assign flag_rd = rd_ev && (addr_s2 == rtcuc_pkg::ADDR_FLAGS);

  // read mux for the selected byte
  always_comb begin
    rd_byte = read_byte(addr_s2);
  end

  function automatic logic [7:0] read_byte(input logic [12:0] a);
    logic [7:0] b;
    b = vis[a[3:0]];
    if (a[12:4] != rtcuc_pkg::REG_PAGE) begin
      b = mem[a];
    end else if (a == rtcuc_pkg::ADDR_FLAGS) begin
      b = {watchdog_flag, af, 1'b0, bl, 4'h0}; // [RQ16]
    end else if (a == rtcuc_pkg::ADDR_SECONDS) begin
      b = {osc_stop, vis[a[3:0]][6:0]};
    end else if (a == rtcuc_pkg::ADDR_CENT_DAY) begin
      b = {1'b0, ft, ceb, vis[a[3:0]][4:0]}; // [RQ18]
    end
    return b;
  endfunction

  // bus next-state
  always_comb begin
    next_rd_prev   = rd_act;
    next_wr_prev   = wr_act;
    next_addr_prev = addr_s2;
    next_wr_addr   = wr_act ? addr_s2 : wr_addr;
    next_wr_data   = wr_act ? dq_s2 : wr_data;
    // data is caught once per read so a cleared flag stays visible until the next read
    next_dq_out    = rd_ev ? rd_byte : DQ_OUT;
    next_dq_oe     = rd_act; // [RQ2]
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_prev   <= 1'b0;
      wr_prev   <= 1'b0;
      addr_prev <= 13'h0000;
      wr_addr   <= 13'h0000;
      wr_data   <= 8'h00;
      DQ_OUT    <= 8'h00;
      DQ_OE     <= 1'b0;
    end else if (CLK_EN) begin
      rd_prev   <= next_rd_prev;
      wr_prev   <= next_wr_prev;
      addr_prev <= next_addr_prev;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
      DQ_OUT    <= next_dq_out;
      DQ_OE     <= next_dq_oe;
    end
  end

  // plain sram; only the addressed byte is ever touched
  always_ff @(posedge SYS_CLK) begin
    if (CLK_EN && commit && !page_wr) begin
      mem[wr_addr] <= wr_data; // [RQ3]
    end
  end

  // timekeeping, refresh sequencer and register writes
  always_comb begin
    logic [8:0] r;
    logic [7:0] idx;
    r  = 9'h000;
    idx = 8'h00;
    next_vis      = vis;
    next_cnt      = cnt;
    next_state    = state;
    next_osc_stop = osc_stop;
    next_ft       = ft;
    next_ceb      = ceb;
    next_bl       = BATTERY_LOW;
    // prescaler; a stopped oscillator restarts from a full second
    next_pre      = (osc_stop || tick) ? 24'h000000 : pre + 24'h000001; // [RQ13]

    // hidden counters always advance, halted or not
    if (tick) begin // [RQ5]
      r = bcd_inc(cnt[0], rtcuc_pkg::BCD_ZERO, rtcuc_pkg::SEC_MAX);
      next_cnt[0] = r[7:0];
      if (r[8]) begin
        r = bcd_inc(cnt[1], rtcuc_pkg::BCD_ZERO, rtcuc_pkg::SEC_MAX);
        next_cnt[1] = r[7:0];
        if (r[8]) begin
          r = bcd_inc(cnt[2], rtcuc_pkg::BCD_ZERO, rtcuc_pkg::HOUR_MAX);
          next_cnt[2] = r[7:0];
          if (r[8]) begin
            r = bcd_inc({5'h00, cnt[3][2:0]}, rtcuc_pkg::BCD_ONE, rtcuc_pkg::DAY_MAX);
            next_cnt[3] = {cnt[3][7:3], r[2:0]};
            r = bcd_inc(cnt[4], rtcuc_pkg::BCD_ONE, month_end(cnt[5], cnt[6]));
            next_cnt[4] = r[7:0];
            if (r[8]) begin
              r = bcd_inc(cnt[5], rtcuc_pkg::BCD_ONE, rtcuc_pkg::MONTH_MAX);
              next_cnt[5] = r[7:0];
              if (r[8]) begin
                r = bcd_inc(cnt[6], rtcuc_pkg::BCD_ZERO, rtcuc_pkg::YEAR_MAX);
                next_cnt[6] = r[7:0];
                if (r[8] && ceb) begin
                  next_cnt[3][rtcuc_pkg::CDW_CB] = ~cnt[3][rtcuc_pkg::CDW_CB];
                end
              end
            end
          end
        end
      end
    end

    // sequencer: the halt is sampled only when a transfer is launched
    unique case (state)
      rtcuc_pkg::S_IDLE: begin
        if (tick && !halted) begin
          next_state = rtcuc_pkg::S_XFER; // [RQ8] [RQ9]
        end
      end
      rtcuc_pkg::S_XFER: begin
        for (int i = 0; i < 7; i++) begin
          next_vis[i + 9] = next_cnt[i]; // [RQ6] [RQ7]
        end
        next_state = rtcuc_pkg::S_IDLE;
      end
      rtcuc_pkg::S_LOAD: begin
        for (int i = 0; i < 7; i++) begin
          next_cnt[i] = vis[i + 9]; // [RQ10]
        end
        next_pre   = 24'h000000;
        next_state = rtcuc_pkg::S_IDLE;
      end
    endcase

    // host writes to the register page; fixed-zero bits are not stored
    if (page_wr) begin
      idx = {4'h0, wr_addr[3:0]};
      unique case (wr_addr)
        rtcuc_pkg::ADDR_FLAGS: begin
          idx = 8'h00; // read-only byte
        end
        rtcuc_pkg::ADDR_CONTROL: begin
          next_vis[idx[3:0]] = wr_data; // [RQ17] [RQ22]
          if (vis[idx[3:0]][rtcuc_pkg::CTL_SET] && !wr_data[rtcuc_pkg::CTL_SET]) begin
            next_state = rtcuc_pkg::S_LOAD; // [RQ10]
          end
        end
        rtcuc_pkg::ADDR_SECONDS: begin
          next_osc_stop      = wr_data[rtcuc_pkg::SEC_STOP]; // [RQ13] [RQ14]
          next_vis[idx[3:0]] = wr_data & rtcuc_pkg::MASK_SEC;
        end
        rtcuc_pkg::ADDR_MINUTES: next_vis[idx[3:0]] = wr_data & rtcuc_pkg::MASK_MIN;   // [RQ15]
        rtcuc_pkg::ADDR_HOURS:   next_vis[idx[3:0]] = wr_data & rtcuc_pkg::MASK_HOUR;  // [RQ15]
        rtcuc_pkg::ADDR_DATE:    next_vis[idx[3:0]] = wr_data & rtcuc_pkg::MASK_DATE;  // [RQ15]
        rtcuc_pkg::ADDR_MONTH:   next_vis[idx[3:0]] = wr_data & rtcuc_pkg::MASK_MONTH; // [RQ15]
        rtcuc_pkg::ADDR_CENT_DAY: begin
          next_ft            = wr_data[rtcuc_pkg::CDW_FT];  // [RQ14]
          next_ceb           = wr_data[rtcuc_pkg::CDW_CEB]; // [RQ14]
          next_vis[idx[3:0]] = wr_data & rtcuc_pkg::MASK_CDW; // [RQ18]
        end
        default: begin
          // alarm, interrupt, watchdog, spare and year bytes keep all bits
          next_vis[idx[3:0]] = wr_data; // [RQ19] [RQ20] [RQ21]
        end
      endcase
    end

    // power returning clears set-time and read-halt
    if (pf_prev && !pf) begin
      next_vis[rtcuc_pkg::ADDR_CONTROL[3:0]][rtcuc_pkg::CTL_SET]  = 1'b0; // [RQ12]
      next_vis[rtcuc_pkg::ADDR_CONTROL[3:0]][rtcuc_pkg::CTL_HALT] = 1'b0; // [RQ12]
    end

    // sticky flags: an event in the clearing cycle still sets the flag
    next_wdf = WATCHDOG_TIMEOUT | (watchdog_flag & !flag_rd); // [RQ23]
    next_af  = ALARM_MATCH | (af & !flag_rd);       // [RQ23]

    // alarm may pull the pin in backup only when enabled for it
    next_irq = (next_af & vis[rtcuc_pkg::ADDR_INT_EN[3:0]][rtcuc_pkg::INT_AFE]
                & (!pf | vis[rtcuc_pkg::ADDR_INT_EN[3:0]][rtcuc_pkg::INT_ABE]))
             | (next_wdf & !vis[rtcuc_pkg::ADDR_WATCHDOG[3:0]][rtcuc_pkg::WD_STEER] & !pf); // [RQ2] [RQ23]
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 16; i++) begin
        vis[i] <= rtcuc_pkg::RESET_BYTE;
      end
      for (int i = 0; i < 7; i++) begin
        cnt[i] <= rtcuc_pkg::RESET_BYTE;
      end
      state    <= rtcuc_pkg::S_IDLE;
      osc_stop <= 1'b0;
      ft       <= 1'b0;
      ceb      <= 1'b0;
      watchdog_flag      <= 1'b0;
      af       <= 1'b0;
      bl       <= 1'b0;
      pf_prev  <= 1'b1;
      irq      <= 1'b0;
      pre      <= 24'h000000;
      IRQ_OE   <= 1'b0;
    end else if (CLK_EN) begin
      vis      <= next_vis;
      cnt      <= next_cnt;
      state    <= next_state;
      osc_stop <= next_osc_stop;
      ft       <= next_ft;
      ceb      <= next_ceb;
      watchdog_flag      <= next_wdf;
      af       <= next_af;
      bl       <= next_bl;
      pf_prev  <= pf;
      irq      <= next_irq;
      pre      <= next_pre;
      IRQ_OE   <= next_irq; // pin pulled low while asserted
    end
  end

  // open-drain pin only ever drives low
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_OUT <= 1'b0;
    end else if (CLK_EN) begin
      IRQ_OUT <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== verif/rtcuc_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcuc_chk (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        CLK_EN,
  // supply and sram bus
  input wire logic        POWER_FAIL_DESELECT_LEVEL,
  input wire logic [12:0] ADDR,
  input wire logic        E_N,
  input wire logic        G_N,
  input wire logic        W_N,
  input wire logic [7:0]  DQ_IN,
  input wire logic [7:0]  DQ_OUT,
  input wire logic        DQ_OE,
  // events and interrupt pin
  input wire logic        WATCHDOG_TIMEOUT,
  input wire logic        ALARM_MATCH,
  input wire logic        BATTERY_LOW,
  input wire logic        IRQ_OUT,
  input wire logic        IRQ_OE
);
  logic rd;
  logic rd_flg;
  logic quiet;
  logic seen_ev;
  logic next_seen_ev;
  // a read as the host applies it with the supply good
  assign rd = !E_N && !G_N && W_N && !POWER_FAIL_DESELECT_LEVEL;
  assign rd_flg = rd && ADDR == rtcuc_pkg::ADDR_FLAGS;
  assign quiet = !WATCHDOG_TIMEOUT && !ALARM_MATCH;
  // remembers any event since reset; the pin may only pull after one
  assign next_seen_ev = seen_ev || WATCHDOG_TIMEOUT || ALARM_MATCH;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seen_ev <= 1'b0;
    end else begin
      seen_ev <= next_seen_ev;
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  // six sampled edges cover two sync flops, the event and the output flop
  sequence s_read;
    rd [*6];
  endsequence
  sequence s_flag_rd;
    rd_flg [*6];
  endsequence
  sequence s_flag_quiet;
    (rd_flg && quiet) [*6];
  endsequence
  a_pf_float: assert property (POWER_FAIL_DESELECT_LEVEL [*5] |-> !DQ_OE)
    else $error("data bus driven while deselected");
  a_read_drive: assert property (s_read |-> DQ_OE)
    else $error("data bus not driven during read");
  a_flags_zero: assert property (s_flag_rd |-> DQ_OUT[5] == 1'b0 && DQ_OUT[3:0] == 4'h0)
    else $error("unused flag bits read nonzero");
  a_flags_bl: assert property ((rd_flg && BATTERY_LOW) [*6] |-> DQ_OUT[4])
    else $error("battery low missing from flags");
  a_flag_release: assert property (s_flag_quiet |-> !IRQ_OE)
    else $error("interrupt held after flags read");
  a_irq_cause: assert property (IRQ_OE |-> seen_ev)
    else $error("interrupt without any event");
  a_wd_irq: assert property ((!POWER_FAIL_DESELECT_LEVEL) [*4] ##0 WATCHDOG_TIMEOUT |-> ##[1:3] IRQ_OE)
    else $error("watchdog event did not pull the pin");
  a_irq_low: assert property (IRQ_OE |-> IRQ_OUT == 1'b0)
    else $error("open drain pin driven high");
endmodule
bind rtcuc_top rtcuc_chk i_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
  .POWER_FAIL_DESELECT_LEVEL(POWER_FAIL_DESELECT_LEVEL), .ADDR(ADDR),
  .E_N(E_N), .G_N(G_N), .W_N(W_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .ALARM_MATCH(ALARM_MATCH),
  .BATTERY_LOW(BATTERY_LOW), .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE)
);
`default_nettype wire

// ==== verif/rtcuc_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtcuc_host (
  // clock
  input  wire logic        sys_clk,
  // sram bus toward the device
  output logic      [12:0] addr,
  output logic             e_n,
  output logic             g_n,
  output logic             w_n,
  output logic      [7:0]  dq_in,
  input  wire logic [7:0]  dq_out
);
  // idle bus at time zero, strobes high
  initial begin
    addr = 13'h0000;
    e_n = 1'b1;
    g_n = 1'b1;
    w_n = 1'b1;
    dq_in = 8'h00;
  end
  // write: strobes low four edges, then high five; callers pass bcd 24 hour
  // values with fixed-zero bits clear
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    dq_in <= d;
    e_n <= 1'b0;
    w_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    e_n <= 1'b1;
    w_n <= 1'b1;
    dq_in <= ~d; // released line shows the inverse, never stale data
    repeat (5) @(posedge sys_clk);
  endtask
  // read: data taken at the sixth edge, three edges after it settles
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    e_n <= 1'b0;
    g_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    d = dq_out;
    e_n <= 1'b1;
    g_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        sys_clk;
  logic        reset_n;
  logic        pf;
  logic        wd_to;
  logic        alm;
  logic        bat_low;
  logic [12:0] addr;
  logic        e_n;
  logic        g_n;
  logic        w_n;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic        dq_oe;
  logic        irq_out;
  logic        irq_oe;
  logic        clk_en;
  logic [7:0]  d;
  logic [7:0]  s1;
  int          mismatches;
  int          comparisons;
  // address, byte written, byte read back
  localparam logic [28:0] ROWS [10] = '{
    {13'h1ff0, 8'hff, 8'h00}, {13'h1ff2, 8'hd9, 8'hd9}, {13'h1ff3, 8'hd9, 8'hd9},
    {13'h1ff4, 8'ha3, 8'ha3}, {13'h1ff5, 8'hb1, 8'hb1}, {13'h1ff6, 8'ha0, 8'ha0},
    {13'h1ff7, 8'h7f, 8'h7f}, {13'h1ff8, 8'h3f, 8'h3f}, {13'h0000, 8'h5a, 8'h5a},
    {13'h1fef, 8'ha5, 8'ha5}};
  // 23:59:58, day 7, 31 december, year 99
  localparam logic [7:0] TIME [7] = '{8'h58, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  // a short second keeps the run small
  rtcuc_top #(.SEC_CYCLES(20)) i_dut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en), .POWER_FAIL_DESELECT_LEVEL(pf),
    .ADDR(addr), .E_N(e_n), .G_N(g_n), .W_N(w_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .WATCHDOG_TIMEOUT(wd_to), .ALARM_MATCH(alm), .BATTERY_LOW(bat_low),
    .IRQ_OUT(irq_out), .IRQ_OE(irq_oe));
  rtcuc_host i_host (
    .sys_clk(sys_clk), .addr(addr), .e_n(e_n), .g_n(g_n), .w_n(w_n), .dq_in(dq_in),
    .dq_out(dq_out));
  // 100 ns period
  always #50 sys_clk = ~sys_clk;
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    pf = 1'b0;
    clk_en = 1'b1;
    wd_to = 1'b0;
    alm = 1'b0;
    bat_low = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    // register and ram cases
    foreach (ROWS[i]) begin
      i_host.wr(ROWS[i][28:16], ROWS[i][15:8]);
      i_host.rd(ROWS[i][28:16], d);
      check(d, ROWS[i][7:0]);
    end
    // set-time freezes the visible bytes while new time is loaded
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h80);
    foreach (TIME[i]) i_host.wr(rtcuc_pkg::ADDR_SECONDS + 13'(i), TIME[i]);
    repeat (50) @(posedge sys_clk);
    i_host.rd(rtcuc_pkg::ADDR_SECONDS, d);
    check(d, 8'h58);
    // release loads counters; halt lands between the first and second tick
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h00);
    repeat (15) @(posedge sys_clk);
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h40);
    i_host.rd(rtcuc_pkg::ADDR_SECONDS, d);
    check(d, 8'h59);
    repeat (40) @(posedge sys_clk);
    i_host.rd(rtcuc_pkg::ADDR_SECONDS, d);
    check(d, 8'h59);
    // counters kept running: after resuming, hours and year have rolled over
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h00);
    repeat (40) @(posedge sys_clk);
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h40);
    i_host.rd(rtcuc_pkg::ADDR_HOURS, d);
    check(d, 8'h00);
    i_host.rd(rtcuc_pkg::ADDR_YEAR, d);
    check(d, 8'h00);
    // stop bit set without set-time: seconds stay put, then move again
    i_host.wr(rtcuc_pkg::ADDR_SECONDS, 8'h80);
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h00);
    repeat (30) @(posedge sys_clk);
    i_host.rd(rtcuc_pkg::ADDR_SECONDS, s1);
    check({7'h00, s1[7]}, 8'h01);
    repeat (60) @(posedge sys_clk);
    i_host.rd(rtcuc_pkg::ADDR_SECONDS, d);
    check(d, s1);
    i_host.wr(rtcuc_pkg::ADDR_SECONDS, 8'h00);
    repeat (60) @(posedge sys_clk);
    i_host.rd(rtcuc_pkg::ADDR_SECONDS, d);
    // the restart write cleared the seconds field, so only a fresh refresh makes it nonzero
    check({7'h00, d != 8'h00 && d[7] == 1'b0}, 8'h01);
    // watchdog then alarm: pin pulls, flags report, one read clears
    bat_low <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wd_to <= (k == 0);
      alm <= (k == 1);
      @(posedge sys_clk);
      wd_to <= 1'b0;
      alm <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({7'h00, irq_oe}, 8'h01);
      i_host.rd(rtcuc_pkg::ADDR_FLAGS, d);
      check(d, k == 0 ? 8'h90 : 8'h50);
      i_host.rd(rtcuc_pkg::ADDR_FLAGS, d);
      check(d, 8'h10);
      check({7'h00, irq_oe}, 8'h00);
    end
    // supply fails in mid-write, then bus traffic is ignored
    i_host.wr(rtcuc_pkg::ADDR_CONTROL, 8'h40);
    fork
      i_host.wr(13'h0010, 8'h11);
      begin
        repeat (2) @(posedge sys_clk);
        pf <= 1'b1;
      end
    join
    i_host.wr(13'h0000, 8'h33);
    i_host.rd(13'h0000, d);
    pf <= 1'b0;
    repeat (8) @(posedge sys_clk);
    i_host.rd(13'h0000, d);
    check(d, 8'h5a);
    i_host.rd(rtcuc_pkg::ADDR_CONTROL, d);
    check(d, 8'h00);
    // mid-run reset clears the register page; outputs stay quiet throughout
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({6'h00, dq_oe, irq_oe}, 8'h00);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    i_host.rd(rtcuc_pkg::ADDR_ALM_SEC, d);
    check(d, 8'h00);
    // a write made while the clock enable is low never reaches the byte
    clk_en <= 1'b0;
    i_host.wr(rtcuc_pkg::ADDR_ALM_SEC, 8'h45);
    clk_en <= 1'b1;
    i_host.rd(rtcuc_pkg::ADDR_ALM_SEC, d);
    check(d, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
